// file: rtl/chan_status_pkg.sv
/*
 Constants for the channel status register bank and its management
 frame engine. Assumes the management clock is sampled by clk_sys_in.
*/
package chan_status_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [4:0] STATUS_ONE_ADDR = 5'h05;
    localparam logic [4:0] ERR_COUNT_ADDR = 5'h0e;
    localparam logic [15:0] STATUS_ONE_RESET = 16'h0000;
    localparam logic [15:0] ERR_COUNT_RESET = 16'h0000;
    localparam logic [15:0] ERR_COUNT_MAX = 16'hffff;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;

    // ----------------------------------------
    // status field positions
    // ----------------------------------------
    localparam int CAL_DONE_POS = 14;
    localparam int GAIN_LOCK_POS = 13;
    localparam int PAT_ALIGN_POS = 12;
    localparam int RS_TIMEOUT_POS = 11;
    localparam int RS_LOCKED_POS = 10;
    localparam int ENC_INVALID_POS = 9;
    localparam int DEC_INVALID_POS = 8;
    localparam int TX_UNDER_POS = 7;
    localparam int TX_OVER_POS = 6;
    localparam int RX_UNDER_POS = 5;
    localparam int RX_OVER_POS = 4;
    localparam int GEN_IN_POS = 3;
    localparam int SIG_ABSENT_POS = 2;
    localparam int CHAN_SYNC_POS = 1;
    localparam int PLL_LOCK_POS = 0;

    // latch kind per bit; bits in neither mask are plain levels
    localparam logic [15:0] LATCH_HIGH_MASK = 16'h0bf4;
    localparam logic [15:0] LATCH_LOW_MASK = 16'h6403;

    // ----------------------------------------
    // management frame
    // ----------------------------------------
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0c;
    localparam logic [4:0] READ_LAST = 5'h10;
    localparam logic [4:0] WRITE_LAST = 5'h11;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [20:0] RS_TIMER_RESET = 21'h000000;

    typedef enum logic [2:0] {
        S_PRE,
        S_HDR,
        S_TA,
        S_RDATA,
        S_WSKIP
    } mdio_state_e;

endpackage

// file: rtl/error_tally.sv
/*
 Saturating error counter, cleared by a read of its register.
 Assumes the caller qualifies decode errors and gives a one-cycle clear.
*/
`timescale 1ns/1ps
module error_tally (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic pattern_check_run_in,
    input wire logic bit_error_in,
    input wire logic decode_error_in,
    input wire logic clear_in,
    output logic [15:0] count_out
);

    logic inc;

    // ----------------------------------------
    // source select
    // ----------------------------------------
    // pattern checking and functional mode share one counter
    assign inc = pattern_check_run_in ? bit_error_in : decode_error_in;

    // ----------------------------------------
    // counter
    // ----------------------------------------
    // an error in the clearing cycle counts as the first of the new run
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            count_out <= chan_status_pkg::ERR_COUNT_RESET;
        end else if (clear_in) begin
            count_out <= {15'h0000, inc};
        end else if (inc && count_out != chan_status_pkg::ERR_COUNT_MAX) begin
            count_out <= 16'(count_out + 16'h0001);
        end
    end

endmodule

// file: rtl/channel_status_register.sv
/*
 Channel status register bank with its serial management slave.
 Assumes status sources and the management clock are synchronous to
 clk_sys_in; the management clock must be slower than a quarter of it.
*/
`timescale 1ns/1ps
// How it works
// - Calibration-done bit rises once offset zeroing has finished.
// - Gain-loop-locked bit latches low when the gain loop loses lock.
// - Pattern-aligned bit shows one once aligned on the right pattern.
// - While pattern checking runs each bit error bumps the counter.
// - Enabled rate sensing that finds no lock in its interval flags.
// - Rate-sense-locked bit rises once the data rate is found.
// - Invalid control words flag only in 16-bit encode or pattern gen.
// - Decode violations flag only in 16-bit decode or pattern check.
// - In functional mode decode violations bump the counter.
// - Transmit fifo underflow and overflow each latch high.
// - Receive fifo underflow and overflow each latch high.
// - The general input level is shown live.
// - Signal loss latches high.
// - Channel sync latches low and counts only with comma detection.
// - Serdes pll lock latches low.
// - Pattern-aligned and general input bits never latch.
module channel_status_register (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_out,
    input wire logic [4:0] phy_addr_in,
    input wire logic offset_cal_done_in,
    input wire logic gain_loop_locked_in,
    input wire logic pattern_check_aligned_in,
    input wire logic pattern_check_run_in,
    input wire logic pattern_bit_error_in,
    input wire logic rate_sense_en_in,
    input wire logic [20:0] rate_sense_interval_in,
    input wire logic rate_sense_pll_lock_in,
    input wire logic rate_sense_locked_in,
    input wire logic mode_16bit_in,
    input wire logic encode_en_in,
    input wire logic decode_en_in,
    input wire logic compliant_random_pattern_gen_in,
    input wire logic compliant_random_pattern_check_in,
    input wire logic encode_invalid_in,
    input wire logic decode_invalid_in,
    input wire logic tx_fifo_underflow_in,
    input wire logic tx_fifo_overflow_in,
    input wire logic rx_fifo_underflow_in,
    input wire logic rx_fifo_overflow_in,
    input wire logic general_input_one_in,
    input wire logic signal_absent_in,
    input wire logic comma_detect_en_in,
    input wire logic chan_sync_in,
    input wire logic serdes_pll_lock_in,
    output logic [15:0] status_word_out,
    output logic [15:0] error_count_out
);

    chan_status_pkg::mdio_state_e state;
    logic mdc_q;
    logic mdc_rise;
    logic [5:0] ones;
    logic [4:0] bit_cnt;
    logic [11:0] hdr_sh;
    logic [12:0] hdr_word;
    logic [15:0] rd_sh;
    logic hdr_done;
    logic hdr_ok;
    logic rd_hit;
    logic wr_hit;
    logic clr_status;
    logic clr_err;
    logic enc_valid;
    logic dec_valid;
    logic dec_err;
    logic [20:0] rs_timer;
    logic rs_timeout;
    logic [15:0] cond;
    logic [15:0] next_status;

    // ----------------------------------------
    // management clock edge
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            mdc_q <= 1'b0;
        end else begin
            mdc_q <= mdc_in;
        end
    end

    assign mdc_rise = mdc_in && !mdc_q;

    // ----------------------------------------
    // frame header decode
    // ----------------------------------------
    assign hdr_done = mdc_rise && state == chan_status_pkg::S_HDR
        && bit_cnt == chan_status_pkg::HDR_LAST;
    assign hdr_word = {hdr_sh, mdio_in};
    assign hdr_ok = hdr_word[12]
        && (hdr_word[11:10] == chan_status_pkg::OP_READ
        || hdr_word[11:10] == chan_status_pkg::OP_WRITE);
    assign rd_hit = hdr_done && hdr_ok && hdr_word[9:5] == phy_addr_in
        && hdr_word[11:10] == chan_status_pkg::OP_READ;
    assign wr_hit = hdr_done && hdr_ok && !rd_hit;
    // snapshot and clear on the same edge so no event slips between
    assign clr_status = rd_hit
        && hdr_word[4:0] == chan_status_pkg::STATUS_ONE_ADDR;
    assign clr_err = rd_hit
        && hdr_word[4:0] == chan_status_pkg::ERR_COUNT_ADDR;

    // ----------------------------------------
    // frame engine
    // ----------------------------------------
    // writes are consumed and dropped: every field here is read-only
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            state <= chan_status_pkg::S_PRE;
            ones <= 6'h00;
            bit_cnt <= 5'h00;
            hdr_sh <= 12'h000;
            rd_sh <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe_out <= 1'b0;
        end else if (mdc_rise) begin
            case (state)
                chan_status_pkg::S_PRE: begin
                    if (mdio_in) begin
                        if (ones != chan_status_pkg::PREAMBLE_ONES) begin
                            ones <= 6'(ones + 6'h01);
                        end
                    end else begin
                        ones <= 6'h00;
                        if (ones == chan_status_pkg::PREAMBLE_ONES) begin
                            state <= chan_status_pkg::S_HDR;
                            bit_cnt <= 5'h00;
                        end
                    end
                end
                chan_status_pkg::S_HDR: begin
                    hdr_sh <= hdr_word[11:0];
                    bit_cnt <= 5'(bit_cnt + 5'h01);
                    if (hdr_done) begin
                        bit_cnt <= 5'h00;
                        if (rd_hit) begin
                            state <= chan_status_pkg::S_TA;
                            if (clr_status) begin
                                rd_sh <= status_word_out;
                            end else if (clr_err) begin
                                rd_sh <= error_count_out;
                            end else begin
                                rd_sh <= chan_status_pkg::UNMAPPED_READ;
                            end
                        end else if (wr_hit) begin
                            state <= chan_status_pkg::S_WSKIP;
                        end else begin
                            state <= chan_status_pkg::S_PRE;
                        end
                    end
                end
                chan_status_pkg::S_TA: begin
                    // second turnaround bit is driven low
                    mdio_oe_out <= 1'b1;
                    mdio_out <= 1'b0;
                    state <= chan_status_pkg::S_RDATA;
                end
                chan_status_pkg::S_RDATA: begin
                    bit_cnt <= 5'(bit_cnt + 5'h01);
                    if (bit_cnt == chan_status_pkg::READ_LAST) begin
                        mdio_oe_out <= 1'b0;
                        mdio_out <= 1'b0;
                        bit_cnt <= 5'h00;
                        state <= chan_status_pkg::S_PRE;
                    end else begin
                        mdio_out <= rd_sh[15];
                        rd_sh <= {rd_sh[14:0], 1'b0};
                    end
                end
                chan_status_pkg::S_WSKIP: begin
                    bit_cnt <= 5'(bit_cnt + 5'h01);
                    if (bit_cnt == chan_status_pkg::WRITE_LAST) begin
                        bit_cnt <= 5'h00;
                        state <= chan_status_pkg::S_PRE;
                    end
                end
                default: begin
                    state <= chan_status_pkg::S_PRE;
                    mdio_oe_out <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // rate-sense lock timer
    // ----------------------------------------
    // counts system clocks; restarts whenever disabled or locked
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in || !rate_sense_en_in || rate_sense_pll_lock_in) begin
            rs_timer <= chan_status_pkg::RS_TIMER_RESET;
        end else if (rs_timer != rate_sense_interval_in) begin
            rs_timer <= 21'(rs_timer + 21'h000001);
        end
    end

    assign rs_timeout = rate_sense_en_in && !rate_sense_pll_lock_in
        && rs_timer == rate_sense_interval_in;

    // ----------------------------------------
    // status conditions
    // ----------------------------------------
    assign enc_valid = (mode_16bit_in && encode_en_in)
        || compliant_random_pattern_gen_in;
    assign dec_valid = (mode_16bit_in && decode_en_in)
        || compliant_random_pattern_check_in;
    assign dec_err = dec_valid && decode_invalid_in;

    always_comb begin
        cond = 16'h0000;
        cond[chan_status_pkg::CAL_DONE_POS] = offset_cal_done_in;
        cond[chan_status_pkg::GAIN_LOCK_POS] = gain_loop_locked_in;
        cond[chan_status_pkg::PAT_ALIGN_POS] =
            pattern_check_aligned_in;
        cond[chan_status_pkg::RS_TIMEOUT_POS] = rs_timeout;
        cond[chan_status_pkg::RS_LOCKED_POS] =
            rate_sense_en_in && rate_sense_locked_in;
        cond[chan_status_pkg::ENC_INVALID_POS] =
            enc_valid && encode_invalid_in;
        cond[chan_status_pkg::DEC_INVALID_POS] = dec_err;
        cond[chan_status_pkg::TX_UNDER_POS] = tx_fifo_underflow_in;
        cond[chan_status_pkg::TX_OVER_POS] = tx_fifo_overflow_in;
        cond[chan_status_pkg::RX_UNDER_POS] = rx_fifo_underflow_in;
        cond[chan_status_pkg::RX_OVER_POS] = rx_fifo_overflow_in;
        cond[chan_status_pkg::GEN_IN_POS] = general_input_one_in;
        cond[chan_status_pkg::SIG_ABSENT_POS] = signal_absent_in;
        cond[chan_status_pkg::CHAN_SYNC_POS] =
            comma_detect_en_in && chan_sync_in;
        cond[chan_status_pkg::PLL_LOCK_POS] = serdes_pll_lock_in;
    end

    // ----------------------------------------
    // per-bit latching
    // ----------------------------------------
    // set wins over a read clear for high latches, loss wins for low
    for (genvar i = 0; i < 16; i++) begin : g_bit
        if (chan_status_pkg::LATCH_HIGH_MASK[i]) begin : g_lh
            assign next_status[i] = clr_status ? cond[i]
                : (status_word_out[i] || cond[i]);
        end else if (chan_status_pkg::LATCH_LOW_MASK[i]) begin : g_ll
            assign next_status[i] = clr_status ? cond[i]
                : (status_word_out[i] && cond[i]);
        end else begin : g_plain
            assign next_status[i] = cond[i];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            status_word_out <= chan_status_pkg::STATUS_ONE_RESET;
        end else begin
            status_word_out <= next_status;
        end
    end

    // ----------------------------------------
    // error counter
    // ----------------------------------------
    error_tally u_tally (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .pattern_check_run_in(pattern_check_run_in),
        .bit_error_in(pattern_bit_error_in),
        .decode_error_in(dec_err),
        .clear_in(clr_err),
        .count_out(error_count_out)
    );

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    sequence s_ta_edge;
        mdc_rise && state == chan_status_pkg::S_TA;
    endsequence

    sequence s_drive_low;
        mdio_oe_out && !mdio_out;
    endsequence

    a_ta_drive: assert property (
        s_ta_edge |=> s_drive_low
    ) else $error("turnaround bit not driven low");

    a_tx_under_set: assert property (
        tx_fifo_underflow_in |=> status_word_out[7]
    ) else $error("tx underflow did not latch");

    a_los_sticky: assert property (
        status_word_out[2] && !clr_status |=> status_word_out[2]
    ) else $error("loss of signal dropped before read");

    a_pll_low_hold: assert property (
        !status_word_out[0] && !clr_status |=> !status_word_out[0]
    ) else $error("pll lock rose before read");

    a_sync_gate: assert property (
        !comma_detect_en_in |=> !status_word_out[1]
    ) else $error("sync shown without comma detection");

    a_enc_gate: assert property (
        !enc_valid && !status_word_out[9] && !clr_status
        |=> !status_word_out[9]
    ) else $error("encode flag raised outside its mode");

    a_gen_in_live: assert property (
        ##1 status_word_out[3] == $past(general_input_one_in)
    ) else $error("general input not live");

    a_rs_timeout: assert property (
        rate_sense_en_in && !rate_sense_pll_lock_in
        && rs_timer == rate_sense_interval_in |=> status_word_out[11]
    ) else $error("rate sense timeout not flagged");

    a_rs_lock_gate: assert property (
        !rate_sense_en_in |=> !status_word_out[10]
    ) else $error("rate lock shown while disabled");

    a_bit_err_count: assert property (
        pattern_check_run_in && pattern_bit_error_in && !clr_err
        && error_count_out != chan_status_pkg::ERR_COUNT_MAX
        |=> error_count_out == 16'($past(error_count_out) + 16'h0001)
    ) else $error("pattern bit error not counted");

    a_read_release: assert property (
        mdc_rise && state == chan_status_pkg::S_RDATA
        && bit_cnt == chan_status_pkg::READ_LAST |=> !mdio_oe_out
    ) else $error("data pin not released after read");

endmodule

// file: verif/mgmt_host.sv
/*
 Management host model: read and write frames on the management clock
 and data pin.
 Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
module mgmt_host (
    input wire logic clk_sys_in,
    input wire logic mdio_wire_in,
    output logic mdc_out,
    output logic mdio_drv_out,
    output logic mdio_en_out
);
    // mdc stands low between frames; four clocks per half keeps it slow
    initial begin
        mdc_out = 1'b0;
        mdio_drv_out = 1'b1;
        mdio_en_out = 1'b0;
    end

    task automatic half_wait();
        repeat (4) @(posedge clk_sys_in);
        #1;
    endtask

    // data changes only while mdc is low, well before the rise
    task automatic send_bit(input logic b);
        mdio_drv_out = b;
        half_wait();
        mdc_out = 1'b1;
        half_wait();
        mdc_out = 1'b0;
    endtask

    task automatic read_frame(input logic [4:0] phy, input logic [4:0] ra,
                              output logic [15:0] data, output logic ta);
        logic [13:0] hdr;
        hdr = {2'b01, chan_status_pkg::OP_READ, phy, ra};
        mdio_en_out = 1'b1;
        repeat (32) send_bit(1'b1);
        for (int i = 13; i >= 0; i--) send_bit(hdr[i]);
        mdio_en_out = 1'b0;
        // sampled just after each fall, while the answer still stands
        for (int i = 0; i < 18; i++) begin
            send_bit(1'b1);
            if (i == 0) ta = mdio_wire_in;
            else if (i < 17) data[16 - i] = mdio_wire_in;
        end
    endtask

    // header, two turnaround bits and sixteen data bits, all host driven
    task automatic write_frame(input logic [4:0] phy, input logic [4:0] ra,
                               input logic [15:0] data);
        logic [31:0] bits;
        bits = {2'b01, chan_status_pkg::OP_WRITE, phy, ra, 2'b10, data};
        mdio_en_out = 1'b1;
        repeat (32) send_bit(1'b1);
        for (int i = 31; i >= 0; i--) send_bit(bits[i]);
        mdio_en_out = 1'b0;
    endtask
endmodule

// file: verif/testbench.sv
/*
 Self-checking bench for the channel status register bank.
 Assumes the management host model drives mdc and the host side of mdio.
*/
`timescale 1ns/1ps
module testbench;
    logic clk_sys_in, nrst_in, mdc, host_d, host_en, mdio_o, mdio_oe, wire_l;
    logic cal, gain, align, run, bit_err, rs_en, rs_pll, rs_lock;
    logic m16, enc_en, dec_en, crp_gen, crp_chk, enc_inv, dec_inv;
    logic tx_u, tx_o, rx_u, rx_o, gen_in, sig_abs, comma, sync, pll;
    logic [20:0] interval;
    logic [15:0] status, errs, d;
    int n_fail = 0;
    int checks_done = 0;
    localparam logic [4:0] PHY = 5'h03;

    // ----------------------------------------
    // clock, wire and instances
    // ----------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    // pull-up: a released pin reads high
    assign wire_l = mdio_oe ? mdio_o : (host_en ? host_d : 1'b1);

    channel_status_register dut_u (.clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in), .mdc_in(mdc), .mdio_in(wire_l),
        .mdio_out(mdio_o), .mdio_oe_out(mdio_oe), .phy_addr_in(PHY),
        .offset_cal_done_in(cal), .gain_loop_locked_in(gain),
        .pattern_check_aligned_in(align), .pattern_check_run_in(run),
        .pattern_bit_error_in(bit_err), .rate_sense_en_in(rs_en),
        .rate_sense_interval_in(interval), .rate_sense_pll_lock_in(rs_pll),
        .rate_sense_locked_in(rs_lock), .mode_16bit_in(m16),
        .encode_en_in(enc_en), .decode_en_in(dec_en),
        .compliant_random_pattern_gen_in(crp_gen),
        .compliant_random_pattern_check_in(crp_chk),
        .encode_invalid_in(enc_inv), .decode_invalid_in(dec_inv),
        .tx_fifo_underflow_in(tx_u), .tx_fifo_overflow_in(tx_o),
        .rx_fifo_underflow_in(rx_u), .rx_fifo_overflow_in(rx_o),
        .general_input_one_in(gen_in), .signal_absent_in(sig_abs),
        .comma_detect_en_in(comma), .chan_sync_in(sync),
        .serdes_pll_lock_in(pll), .status_word_out(status),
        .error_count_out(errs));

    mgmt_host host_u (.clk_sys_in(clk_sys_in), .mdio_wire_in(wire_l),
        .mdc_out(mdc), .mdio_drv_out(host_d), .mdio_en_out(host_en));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input logic [4:0] phy, input logic [4:0] ra);
        logic t;
        host_u.read_frame(phy, ra, d, t);
        if (phy == PHY) chk("turnaround", 16'h0000, {15'h0, t});
        step(2);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk("status after reset", 16'h0000, status);
        rd(PHY, chan_status_pkg::STATUS_ONE_ADDR);
        chk("reset read", 16'h0000, d);
        rd(PHY, 5'h03);
        chk("unmapped read", 16'h0000, d);
        rd(5'h07, chan_status_pkg::STATUS_ONE_ADDR);
        chk("other address, pin released", 16'hffff, d);
        $display("test reset done");
    endtask

    task automatic t_levels();
        {cal, gain, align, rs_en, rs_pll, rs_lock} = 6'h3f;
        {comma, sync, pll, gen_in} = 4'hf;
        step(3);
        chk("low latches held", 16'h1008, status);
        rd(PHY, chan_status_pkg::STATUS_ONE_ADDR);
        chk("read before clear", 16'h1008, d);
        chk("live after read", 16'h740b, status);
        pll = 1'b0;
        step(1);
        pll = 1'b1;
        {gen_in, align} = 2'b00;
        step(3);
        chk("pll loss held", 16'h6402, status);
        rd(PHY, chan_status_pkg::STATUS_ONE_ADDR);
        chk("read pll loss", 16'h6402, d);
        chk("restored", 16'h6403, status);
        comma = 1'b0;
        step(3);
        chk("sync without comma", 16'h6401, status);
        comma = 1'b1;
        rd(PHY, chan_status_pkg::STATUS_ONE_ADDR);
        $display("test levels done");
    endtask

    task automatic t_events();
        logic [15:0] ev[5] = '{16'h0080, 16'h0040, 16'h0020, 16'h0010,
                               16'h0004};
        logic [15:0] acc;
        acc = 16'h6403;
        for (int i = 0; i < 5; i++) begin
            {tx_u, tx_o, rx_u, rx_o, sig_abs} = 5'h10 >> i;
            step(1);
            {tx_u, tx_o, rx_u, rx_o, sig_abs} = 5'h00;
            step(4);
            acc = acc | ev[i];
            chk("event latched", acc, status);
        end
        // a write must neither clear latches nor upset frame alignment
        host_u.write_frame(PHY, chan_status_pkg::STATUS_ONE_ADDR, 16'h0000);
        step(2);
        chk("held over write", 16'h64f7, status);
        rd(PHY, chan_status_pkg::STATUS_ONE_ADDR);
        chk("events read", 16'h64f7, d);
        chk("events cleared", 16'h6403, status);
        $display("test events done");
    endtask

    task automatic t_coding();
        {m16, enc_en, enc_inv} = 3'b011;
        step(1);
        enc_inv = 1'b0;
        step(2);
        chk("encode outside 16-bit", 16'h0000, status & 16'h0200);
        {m16, enc_inv} = 2'b11;
        step(1);
        enc_inv = 1'b0;
        step(2);
        chk("encode in 16-bit", 16'h0200, status & 16'h0200);
        {m16, dec_en, dec_inv} = 3'b011;
        step(1);
        dec_inv = 1'b0;
        step(2);
        chk("decode outside 16-bit", 16'h0000, status & 16'h0100);
        chk("unqualified count", 16'h0000, errs);
        {m16, dec_inv} = 2'b11;
        step(2);
        {m16, crp_chk} = 2'b01;
        step(1);
        dec_inv = 1'b0;
        step(2);
        chk("decode flagged", 16'h0100, status & 16'h0100);
        chk("decode count", 16'h0003, errs);
        rd(PHY, chan_status_pkg::ERR_COUNT_ADDR);
        chk("count read", 16'h0003, d);
        chk("count cleared", 16'h0000, errs);
        {crp_chk, enc_en, dec_en} = 3'b000;
        rd(PHY, chan_status_pkg::STATUS_ONE_ADDR);
        crp_gen = 1'b1;
        enc_inv = 1'b1;
        step(1);
        enc_inv = 1'b0;
        step(2);
        chk("encode in pattern gen", 16'h0200, status & 16'h0200);
        crp_gen = 1'b0;
        rd(PHY, chan_status_pkg::STATUS_ONE_ADDR);
        $display("test coding done");
    endtask

    task automatic t_pattern();
        {run, bit_err, m16, dec_en, dec_inv} = 5'h1f;
        step(1);
        dec_inv = 1'b0;
        step(2);
        bit_err = 1'b0;
        step(2);
        chk("bit errors counted", 16'h0003, errs);
        {run, m16, dec_en} = 3'b000;
        rd(PHY, chan_status_pkg::STATUS_ONE_ADDR);
        $display("test pattern done");
    endtask

    task automatic t_rate();
        interval = 21'h000014;
        rs_pll = 1'b0;
        step(10);
        chk("no timeout yet", 16'h0000, status & 16'h0800);
        step(15);
        chk("timeout", 16'h0800, status & 16'h0800);
        rs_en = 1'b0;
        step(2);
        rd(PHY, chan_status_pkg::STATUS_ONE_ADDR);
        chk("timeout read", 16'h0800, d & 16'h0800);
        step(30);
        chk("disabled no timeout", 16'h0000, status & 16'h0800);
        $display("test rate done");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        nrst_in = 1'b0;
        {cal, gain, align, run, bit_err, rs_en, rs_pll, rs_lock} = 8'h00;
        {m16, enc_en, dec_en, crp_gen, crp_chk, enc_inv, dec_inv} = 7'h00;
        {tx_u, tx_o, rx_u, rx_o, gen_in, sig_abs, comma, sync, pll} = 9'h000;
        interval = 21'h000064;
        step(3);
        nrst_in = 1'b1;
        step(1);
        t_reset();
        t_levels();
        t_events();
        t_coding();
        t_pattern();
        t_rate();
        results();
    end

    initial begin
        repeat (60000) @(posedge clk_sys_in);
        n_fail++;
        results();
    end
endmodule
